/* File: rgh_regs.svh */
`ifndef RGH_REGS_SVH
`define RGH_REGS_SVH

// ---------------------------------------------------------------
// controller register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define RGH_OFF_CTRL 8'h00
`define RGH_OFF_STATUS 8'h04
`define RGH_OFF_TXDATA 8'h08
`define RGH_OFF_RXDATA 8'h0C
`define RGH_CTRL_MASK 32'h0000001F
`define RGH_CTRL_RST 32'h00000000
`define RGH_W1C_MASK 32'h00000026

// ---------------------------------------------------------------
// device-side map, reached through the device management port
// ---------------------------------------------------------------
`define RGH_DEV_TIMING_MODE 16'h0032
`define RGH_DEV_CLOCK_SKEW 16'h0086

// ---------------------------------------------------------------
// timing: host clock and link half periods in picoseconds
// ---------------------------------------------------------------
`define RGH_HCLK_PS 5000
`define RGH_HALF_1G_PS 4000
`define RGH_HALF_100M_PS 20000
`define RGH_HALF_10M_PS 200000
`define RGH_HALF_CNT(ps) ((((ps) / `RGH_HCLK_PS) < 1) ? 1 : ((ps) / `RGH_HCLK_PS))
`define RGH_HALF_W 8

`endif

/* File: rgh_pkg.sv */
package rgh_pkg;

  typedef enum logic [1:0] {
    RGH_10M = 2'h0,
    RGH_100M = 2'h1,
    RGH_1G = 2'h2,
    RGH_SPD_RSV = 2'h3
  } rgh_speed_t;

  typedef enum logic [1:0] {
    RGH_TX_IDLE = 2'b01,
    RGH_TX_BYTE = 2'b10
  } rgh_tx_state_t;

  typedef struct packed {
    logic [26:0] rsv;
    logic mii;
    logic speed_ok;
    rgh_speed_t speed;
    logic enable;
  } rgh_ctrl_t;

  typedef struct packed {
    logic [15:0] frames;
    logic [4:0] rsv;
    logic duplex;
    rgh_speed_t link_speed;
    logic link_up;
    logic mii_speed_err;
    logic tx_underrun;
    logic tx_busy;
    logic tx_full;
    logic rx_err;
    logic rx_overflow;
    logic rx_valid;
  } rgh_status_t;

  typedef struct packed {
    logic [21:0] rsv;
    logic err;
    logic last;
    logic [7:0] data;
  } rgh_word_t;

  typedef struct packed {
    logic duplex;
    rgh_speed_t speed;
    logic link;
  } rgh_inband_t;

  typedef struct packed {
    logic clk;
    logic ctl;
    logic er;
    logic [3:0] d;
  } rgh_tx_pins_t;

endpackage

/* File: rgh_host.sv */
// Added by the designer: the AHB-Lite slave port.
`include "rgh_regs.svh"

module rgh_host (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // transmit pins toward the device
  output logic tx_clk,
  output logic tx_ctl,
  output logic tx_er,
  output logic [3:0] txd,
  // receive pins from the device
  input wire logic rx_clk,
  input wire logic rx_ctl,
  input wire logic rx_er,
  input wire logic [3:0] rxd
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rgh_pkg::rgh_ctrl_t ctrl;
  rgh_pkg::rgh_word_t tx_hold;
  rgh_pkg::rgh_word_t rx_word;
  rgh_pkg::rgh_inband_t inband;
  rgh_pkg::rgh_tx_pins_t pins;
  rgh_pkg::rgh_tx_state_t tx_state;
  rgh_pkg::rgh_status_t status;
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic addr_ok;
  logic wr_fire;
  logic rd_rx;
  logic tx_full;
  logic tx_take;
  logic tx_underrun;
  logic rx_overflow;
  logic rx_err;
  logic [15:0] frames;
  logic gig;
  logic mii_bad;
  logic run_clk;
  logic [`RGH_HALF_W-1:0] half_cnt;
  logic [`RGH_HALF_W-1:0] cnt;
  logic tick;
  logic fall_ev;
  logic rise_ev;
  logic tx_en;
  logic tx_err;
  logic tx_last;
  logic tx_hi_pend;
  logic [7:0] tx_byte;
  logic [3:0] tx_hi_nib;
  logic [6:0] s1;
  logic [6:0] s2;
  logic [6:0] s3;
  logic rx_lvl;
  logic rx_stable;
  logic rrise;
  logic rfall;
  logic ctl_s;
  logic er_s;
  logic [3:0] d_s;
  logic rx_dv_q;
  logic [3:0] rx_lo;
  logic rx_have;
  logic nib_err;
  logic deliver;
  logic [7:0] dbyte;
  logic derr;

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  assign addr_ok = hsel & htrans[1] & hready;
  // a byte write waits while the single holding register is full
  assign hreadyout = ~(dp_valid & dp_write & (dp_addr == `RGH_OFF_TXDATA) & tx_full);
  assign hresp = 1'b0;
  assign wr_fire = dp_valid & dp_write & hreadyout;
  assign rd_rx = addr_ok & ~hwrite & (haddr[7:0] == `RGH_OFF_RXDATA);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end
    else if (ce)
    begin
      if (addr_ok)
      begin
        dp_valid <= 1'b1;
        dp_write <= hwrite;
        dp_addr <= haddr[7:0];
      end
      else if (hreadyout)
        dp_valid <= 1'b0;
    end

  always_comb
  begin
    status = '0;
    status.frames = frames;
    status.duplex = inband.duplex;
    status.link_speed = inband.speed;
    status.link_up = inband.link;
    status.mii_speed_err = mii_bad;
    status.tx_underrun = tx_underrun;
    status.tx_busy = (tx_state == rgh_pkg::RGH_TX_BYTE);
    status.tx_full = tx_full;
    status.rx_err = rx_err;
    status.rx_overflow = rx_overflow;
    status.rx_valid = rx_word.rsv[0];
  end

  // read data is registered in the address phase: zero wait states
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ce && addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        `RGH_OFF_CTRL: hrdata <= ctrl;
        `RGH_OFF_STATUS: hrdata <= status;
        `RGH_OFF_RXDATA: hrdata <= {22'h000000, rx_word.err, rx_word.rsv[0], rx_word.data};
        default: hrdata <= 32'h00000000;
      endcase
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctrl <= rgh_pkg::rgh_ctrl_t'(`RGH_CTRL_RST);
    else if (ce && wr_fire && dp_addr == `RGH_OFF_CTRL)
      ctrl <= rgh_pkg::rgh_ctrl_t'(hwdata & `RGH_CTRL_MASK);

  // ---------------------------------------------------------------
  // speed selection and transmit clock divider
  // ---------------------------------------------------------------
  assign gig = (ctrl.speed == rgh_pkg::RGH_1G);
  assign mii_bad = ctrl.mii & gig;
  assign run_clk = ctrl.enable & ctrl.speed_ok & ~mii_bad;

  always_comb
    case (ctrl.speed)
      rgh_pkg::RGH_1G: half_cnt = `RGH_HALF_W'(`RGH_HALF_CNT(`RGH_HALF_1G_PS));
      rgh_pkg::RGH_100M: half_cnt = `RGH_HALF_W'(`RGH_HALF_CNT(`RGH_HALF_100M_PS));
      default: half_cnt = `RGH_HALF_W'(`RGH_HALF_CNT(`RGH_HALF_10M_PS));
    endcase

  assign tick = (cnt == '0);
  assign fall_ev = tick & pins.clk;
  assign rise_ev = tick & ~pins.clk & run_clk;

  // speed changes and stops only take effect at half-period ends, so the
  // clock never shows a short pulse; a stop always completes the high phase
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      cnt <= '0;
      pins.clk <= 1'b0;
    end
    else if (ce)
    begin
      if (fall_ev || rise_ev)
      begin
        pins.clk <= rise_ev;
        cnt <= half_cnt - `RGH_HALF_W'(1);
      end
      else if (!tick)
        cnt <= cnt - `RGH_HALF_W'(1);
    end

  // ---------------------------------------------------------------
  // transmit holding register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_full <= 1'b0;
      tx_hold <= '0;
    end
    else if (ce)
    begin
      if (wr_fire && dp_addr == `RGH_OFF_TXDATA)
      begin
        tx_full <= 1'b1;
        tx_hold <= rgh_pkg::rgh_word_t'(hwdata);
      end
      else if (tx_take)
        tx_full <= 1'b0;
    end

  // ---------------------------------------------------------------
  // transmit engine: pins set half a period before the edge sampling them
  // ---------------------------------------------------------------
  assign tx_take = fall_ev & ~tx_hi_pend & tx_full & run_clk
                   & ~(tx_state == rgh_pkg::RGH_TX_BYTE & tx_last);

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tx_state <= rgh_pkg::RGH_TX_IDLE;
      tx_en <= 1'b0;
      tx_err <= 1'b0;
      tx_last <= 1'b0;
      tx_hi_pend <= 1'b0;
      tx_byte <= 8'h00;
      tx_hi_nib <= 4'h0;
      pins.ctl <= 1'b0;
      pins.er <= 1'b0;
      pins.d <= 4'h0;
    end
    else if (ce)
    begin
      if (fall_ev)
      begin
        if (tx_hi_pend)
        begin
          // second cycle of a byte at 10/100: high nibble on both edges
          pins.d <= tx_byte[7:4];
          tx_hi_nib <= tx_byte[7:4];
          tx_hi_pend <= 1'b0;
        end
        else
        begin
          case (tx_state)
            rgh_pkg::RGH_TX_IDLE,
            rgh_pkg::RGH_TX_BYTE:
            begin
              if (tx_take)
              begin
                tx_state <= rgh_pkg::RGH_TX_BYTE;
                tx_en <= 1'b1;
                tx_err <= tx_hold.err;
                tx_last <= tx_hold.last;
                tx_byte <= tx_hold.data;
                tx_hi_pend <= ~gig | ctrl.mii;
                pins.d <= tx_hold.data[3:0];
                tx_hi_nib <= gig ? tx_hold.data[7:4] : tx_hold.data[3:0];
              end
              else if (tx_state == rgh_pkg::RGH_TX_BYTE && !tx_last)
              begin
                // no byte ready mid-frame: send an error cycle, keep frame open
                tx_err <= 1'b1;
                pins.d <= 4'h0;
                tx_hi_nib <= 4'h0;
              end
              else
              begin
                // frame done: at least one idle cycle before the next frame
                tx_state <= rgh_pkg::RGH_TX_IDLE;
                tx_en <= 1'b0;
                tx_err <= 1'b0;
                pins.d <= 4'h0;
                tx_hi_nib <= 4'h0;
              end
            end
            default: tx_state <= rgh_pkg::RGH_TX_IDLE;
          endcase
        end
      end
      if (fall_ev)
        pins.ctl <= tx_take | (tx_en & (tx_hi_pend | ~tx_last | tx_state != rgh_pkg::RGH_TX_BYTE)
                    & ~(tx_state == rgh_pkg::RGH_TX_IDLE & ~tx_take));
      if (fall_ev)
        pins.er <= ctrl.mii & (tx_take ? tx_hold.err : (tx_hi_pend ? tx_err : tx_state ==
                   rgh_pkg::RGH_TX_BYTE & ~tx_last));
      if (rise_ev && !ctrl.mii)
      begin
        pins.d <= tx_hi_nib;
        pins.ctl <= pins.ctl ^ (tx_err & pins.ctl);
      end
    end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      tx_underrun <= 1'b0;
    else if (ce)
      tx_underrun <= (fall_ev & ~tx_hi_pend & ~tx_take & tx_state == rgh_pkg::RGH_TX_BYTE
                     & ~tx_last) | (tx_underrun & ~(wr_fire & dp_addr == `RGH_OFF_STATUS
                     & hwdata[5]));

  assign tx_clk = pins.clk;
  assign tx_ctl = pins.ctl;
  assign tx_er = pins.er;
  assign txd = pins.d;

  // ---------------------------------------------------------------
  // receive synchroniser: three stages, edge once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      s1 <= 7'h00;
      s2 <= 7'h00;
      s3 <= 7'h00;
      rx_lvl <= 1'b0;
    end
    else if (ce)
    begin
      s1 <= {rx_clk, rx_ctl, rx_er, rxd};
      s2 <= s1;
      s3 <= s2;
      if (rx_stable)
        rx_lvl <= s3[6];
    end

  assign rx_stable = (s2[6] == s3[6]);
  // edges count on levels, so a stretched phase only delays the next byte
  assign rrise = rx_stable & s3[6] & ~rx_lvl;
  assign rfall = rx_stable & ~s3[6] & rx_lvl;
  assign ctl_s = s3[5];
  assign er_s = s3[4];
  assign d_s = s3[3:0];

  // ---------------------------------------------------------------
  // receive decoder
  // ---------------------------------------------------------------
  always_comb
  begin
    deliver = 1'b0;
    dbyte = 8'h00;
    derr = 1'b0;
    if (rrise && ctl_s && (ctrl.mii || !gig) && rx_have)
    begin
      deliver = 1'b1;
      dbyte = {d_s, rx_lo};
      derr = nib_err | (ctrl.mii & er_s);
    end
    if (rfall && rx_dv_q && !ctrl.mii && gig)
    begin
      deliver = 1'b1;
      dbyte = {d_s, rx_lo};
      derr = ctl_s ^ rx_dv_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rx_dv_q <= 1'b0;
      rx_lo <= 4'h0;
      rx_have <= 1'b0;
      nib_err <= 1'b0;
      inband <= '0;
      frames <= 16'h0000;
    end
    else if (ce)
    begin
      if (rrise)
      begin
        rx_dv_q <= ctl_s;
        if (ctl_s && !rx_have)
          rx_lo <= d_s;
        if (ctl_s && (ctrl.mii || !gig))
          rx_have <= ~rx_have;
        if (!ctl_s && !ctrl.mii)
          inband <= rgh_pkg::rgh_inband_t'(d_s);
        if (!ctl_s && rx_dv_q)
        begin
          frames <= frames + 16'h0001;
          rx_have <= 1'b0;
        end
      end
      if (deliver)
        nib_err <= 1'b0;
      else if (rfall && rx_dv_q && !ctrl.mii)
        nib_err <= nib_err | (ctl_s ^ rx_dv_q);
      else if (rrise && ctrl.mii && ctl_s)
        nib_err <= nib_err | er_s;
    end

  // a byte that arrives as software reads the last one is kept: set wins
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rx_word <= '0;
      rx_overflow <= 1'b0;
      rx_err <= 1'b0;
    end
    else if (ce)
    begin
      rx_word.rsv[0] <= deliver | (rx_word.rsv[0] & ~rd_rx);
      if (deliver)
      begin
        rx_word.data <= dbyte;
        rx_word.err <= derr;
      end
      rx_overflow <= (deliver & rx_word.rsv[0] & ~rd_rx)
                     | (rx_overflow & ~(wr_fire & dp_addr == `RGH_OFF_STATUS & hwdata[1]));
      rx_err <= (deliver & derr)
                | (rx_err & ~(wr_fire & dp_addr == `RGH_OFF_STATUS & hwdata[2]));
    end

endmodule // rgh_host

/* File: rgh_host_sva.sv */
`include "rgh_regs.svh"

module rgh_host_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // link side
  input wire logic tx_clk,
  input wire logic tx_ctl,
  input wire logic tx_er,
  input wire logic [3:0] txd
);
  // ------
  // shadow of the control word
  // ------
  logic wp;
  logic run;
  logic [4:0] ctl_c;
  logic [7:0] hi_cnt;
  logic [7:0] stop_cnt;
  logic [7:0] half;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wp <= 1'b0;
    else if (hready)
      wp <= hsel && htrans[1] && hwrite && haddr[7:0] == `RGH_OFF_CTRL;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ctl_c <= 5'h00;
    else if (wp && hready)
      ctl_c <= hwdata[4:0];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hi_cnt <= 8'h00;
    else
      hi_cnt <= tx_clk ? hi_cnt + 8'h01 : 8'h00;
  // saturates so a long stop never wraps back under the bound
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      stop_cnt <= 8'h00;
    else if (run)
      stop_cnt <= 8'h00;
    else if (stop_cnt != 8'hFF)
      stop_cnt <= stop_cnt + 8'h01;
  assign run = ctl_c[0] && ctl_c[3] && !(ctl_c[4] && ctl_c[2:1] == 2'h2);
  assign half = ctl_c[2:1] == 2'h2 ? 8'h01 : (ctl_c[2:1] == 2'h1 ? 8'h04 : 8'h28);

  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_rd_ctrl;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `RGH_OFF_CTRL;
  endsequence
  sequence s_hi4;
    tx_clk [*4] ##1 !tx_clk;
  endsequence
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  property p_ctrl_rd;
    s_rd_ctrl |=> hrdata == {27'h0, ctl_c};
  endproperty
  property p_half;
    $fell(tx_clk) |-> hi_cnt == half;
  endproperty
  property p_half_100m;
    $rose(tx_clk) && ctl_c[2:1] == 2'h1 |-> s_hi4;
  endproperty
  property p_low_bound;
    $fell(tx_clk) && run |-> ##[1:45] ($rose(tx_clk) || !run);
  endproperty
  property p_stop;
    stop_cnt > 8'h32 |-> !tx_clk && !tx_ctl;
  endproperty
  // at 10/100 a nibble changes only as the clock falls; control may also
  // change at the rising edge, where it turns into enable xor error
  property p_nib_hold;
    ctl_c[2:1] != 2'h2 && !$fell(tx_clk) |-> $stable(txd) && ($stable(tx_ctl) || $rose(tx_clk));
  endproperty
  property p_er_rgmii;
    !ctl_c[4] |-> !tx_er;
  endproperty

  a_resp_okay: assert property (p_resp_okay)
    else $error("bus response not okay");
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control readback wrong");
  a_half: assert property (p_half)
    else $error("tx clock high phase wrong length");
  a_half_100m: assert property (p_half_100m)
    else $error("tx clock half period wrong at 100M");
  a_low_bound: assert property (p_low_bound)
    else $error("tx clock stalled while running");
  a_stop: assert property (p_stop)
    else $error("tx clock or control active while stopped");
  a_nib_hold: assert property (p_nib_hold)
    else $error("nibble changed inside its clock cycle");
  a_er_rgmii: assert property (p_er_rgmii)
    else $error("error pin driven outside nibble mode");
endmodule // rgh_host_sva

bind rgh_host rgh_host_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hresp, .hrdata, .tx_clk, .tx_ctl, .tx_er, .txd);

/* File: rgh_dev_model.sv */
module rgh_dev_model (
  // transmit pins from the controller
  input wire logic tx_clk,
  input wire logic tx_ctl,
  input wire logic tx_er,
  input wire logic [3:0] txd,
  input wire logic mii,
  // receive pins toward the controller
  output logic rx_clk,
  output logic rx_ctl,
  output logic rx_er,
  output logic [3:0] rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // device side of the link
  // ------
  logic ph = 1'b0;
  logic e = 1'b0;
  logic [3:0] lo;
  logic [8:0] got_w;
  event got_ev;
  // pins as they stood just before a clock edge: the controller moves
  // data in the same time step as its clock, so an edge must not see it
  logic qc = 1'b0;
  logic qe = 1'b0;
  logic [3:0] qd = 4'h0;

  always @(tx_ctl, tx_er, txd)
    {qe, qc, qd} <= #1 {tx_er, tx_ctl, txd};

  initial
  begin
    rx_clk = 1'b0;
    rx_ctl = 1'b0;
    rx_er = 1'b0;
    rxd = 4'h0;
  end
  // low nibble first, byte complete on the high nibble cycle
  always @(posedge tx_clk)
    if (!qc)
      ph = 1'b0;
    else if (!ph)
    begin
      lo = qd;
      ph = 1'b1;
    end
    else
    begin
      got_w = {e, qd, lo};
      ph = 1'b0;
      -> got_ev;
    end
  always @(negedge tx_clk)
    if (ph)
      e = mii ? qe : !qc;

  // data moves mid-phase so it is steady around both edges
  task automatic nib(input logic [3:0] d, input logic c_r, input logic c_f);
    #20 rxd = d;
    rx_ctl = c_r;
    #20 rx_clk = 1'b1;
    #20 rx_ctl = c_f;
    #20 rx_clk = 1'b0;
  endtask
  task automatic rx_byte(input logic [7:0] b, input logic er);
    nib(b[3:0], 1'b1, !er);
    nib(b[7:4], 1'b1, 1'b1);
  endtask
  // clock then stands still until the next frame
  task automatic rx_end(input logic [3:0] st);
    nib(st, 1'b0, 1'b0);
  endtask
endmodule // rgh_dev_model

/* File: test_rgh_host.sv */
`include "rgh_regs.svh"
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end

module test_rgh_host;
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // bench signals
  // ------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic mii = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, tx_clk, tx_ctl, tx_er, rx_clk, rx_ctl, rx_er;
  logic [3:0] txd, rxd, st;
  logic [7:0] b;
  logic [8:0] t;
  logic [31:0] hrdata, rr, rv, d, e, m;
  logic [31:0] eq[$], mq[$];
  logic [8:0] txq[$];
  int n_tests = 0;
  int n_mismatch = 0;
  event rd_ev;

  always #2.5 hclk = ~hclk;

  rgh_host dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .tx_clk(tx_clk),
    .tx_ctl(tx_ctl), .tx_er(tx_er), .txd(txd), .rx_clk(rx_clk), .rx_ctl(rx_ctl),
    .rx_er(rx_er), .rxd(rxd));
  rgh_dev_model dev (.tx_clk(tx_clk), .tx_ctl(tx_ctl), .tx_er(tx_er), .txd(txd),
    .mii(mii), .rx_clk(rx_clk), .rx_ctl(rx_ctl), .rx_er(rx_er), .rxd(rxd));

  // hready and read data are taken as they stand just before the edge
  task automatic step;
    logic rdy;
    rdy = 1'b0;
    while (rdy !== 1'b1)
    begin
      @(negedge hclk);
      rdy = hready;
      rr = hrdata;
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    step();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
    eq.push_back(ex);
    mq.push_back(mk);
    ahb(1'b0, a, 32'h0);
    rv = rr;
    -> rd_ev;
  endtask
  task automatic frame;
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($urandom);
      txq.push_back({i == 1, b});
      ahb(1'b1, `RGH_OFF_TXDATA, {22'h0, i == 1, i == 3, b});
    end
    for (int i = 0; i < 400 && txq.size() != 0; i++)
      @(posedge hclk);
    `CHK(txq.size(), 0)
    rd(`RGH_OFF_STATUS, 32'h0, 32'h20);
  endtask
  task automatic rxb(input logic [7:0] v, input logic er);
    dev.rx_byte(v, er);
    @(posedge hclk);
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(rd_ev)
  begin
    m = mq.pop_front();
    e = eq.pop_front();
    `CHK(rv & m, e)
  end
  always @(dev.got_ev)
  begin
    t = txq.pop_front();
    `CHK(dev.got_w, t)
  end

  initial
  begin
    #100000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    void'($urandom(18));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`RGH_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(`RGH_OFF_STATUS, 32'h0, 32'hFFFF007F);
    ahb(1'b1, 8'h10, $urandom);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    d = $urandom & 32'hFFFFFFFE;
    ahb(1'b1, `RGH_OFF_CTRL, d);
    rd(`RGH_OFF_CTRL, d & `RGH_CTRL_MASK, 32'hFFFFFFFF);
    // disable before each speed change so no phase is cut short
    for (int i = 0; i < 4; i++)
    begin
      ahb(1'b1, `RGH_OFF_CTRL, 32'h9 | (32'(i) << 1));
      repeat (200) @(posedge hclk);
      ahb(1'b1, `RGH_OFF_CTRL, 32'(i) << 1);
      repeat (60) @(posedge hclk);
    end
    ahb(1'b1, `RGH_OFF_CTRL, 32'h03);
    repeat (80) @(posedge hclk);
    ahb(1'b1, `RGH_OFF_CTRL, 32'h1D);
    repeat (80) @(posedge hclk);
    rd(`RGH_OFF_STATUS, 32'h40, 32'h40);
    ahb(1'b1, `RGH_OFF_CTRL, 32'h0B);
    frame();
    ahb(1'b1, `RGH_OFF_CTRL, 32'h02);
    mii <= 1'b1;
    ahb(1'b1, `RGH_OFF_CTRL, 32'h1B);
    frame();
    ahb(1'b1, `RGH_OFF_CTRL, 32'h12);
    mii <= 1'b0;
    ahb(1'b1, `RGH_OFF_CTRL, 32'h0B);
    for (int i = 0; i < 3; i++)
    begin
      b = 8'($urandom);
      rxb(b, i == 1);
      rd(`RGH_OFF_RXDATA, {22'h0, i == 1, 1'b1, b}, 32'h3FF);
    end
    st = 4'($urandom);
    dev.rx_end(st);
    repeat (10) @(posedge hclk);
    rd(`RGH_OFF_STATUS, {16'h1, 5'h0, st, 7'h0}, 32'hFFFF0780);
    rd(`RGH_OFF_RXDATA, 32'h0, 32'h100);
    rxb(8'($urandom), 1'b0);
    rxb(8'($urandom), 1'b0);
    dev.rx_end(st);
    @(posedge hclk);
    rd(`RGH_OFF_STATUS, 32'h2, 32'h2);
    ahb(1'b1, `RGH_OFF_STATUS, 32'h2);
    rd(`RGH_OFF_STATUS, 32'h0, 32'h2);
    final_report();
  end
endmodule // test_rgh_host
